// ===== logic/dtm_pkg.sv
// Constants, register offsets and carrier types of the dual 16-bit timer block.
package dtm_pkg;

  localparam int NCH = 2;
  localparam int ADDR_W = 8;

  // Register byte offsets; per-channel registers step by one word.
  localparam logic [7:0] ADDR_CFG   = 8'h00;
  localparam logic [7:0] ADDR_MODE0 = 8'h04;
  localparam logic [7:0] ADDR_CTL   = 8'h0C;
  localparam logic [7:0] ADDR_IMR   = 8'h18;
  localparam logic [7:0] ADDR_RIS   = 8'h1C;
  localparam logic [7:0] ADDR_MIS   = 8'h20;
  localparam logic [7:0] ADDR_ICR   = 8'h24;
  localparam logic [7:0] ADDR_ILR0  = 8'h28;
  localparam logic [7:0] ADDR_MAT0  = 8'h30;
  localparam logic [7:0] ADDR_PR0   = 8'h38;
  localparam logic [7:0] ADDR_VAL0  = 8'h48;
  localparam logic [7:0] ADDR_STEP  = 8'h04;

  // Configuration and mode encodings.
  localparam logic [2:0] CFG_SPLIT     = 3'h4;
  localparam logic [1:0] MODE_ONESHOT  = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE  = 2'h3;
  localparam logic [1:0] EVT_RISE      = 2'h0;
  localparam logic [1:0] EVT_FALL      = 2'h1;
  localparam logic [1:0] EVT_BOTH      = 2'h3;

  // Field positions in the control, interrupt and mode words; channels sit one byte apart in the control and interrupt words.
  localparam int CH_STRIDE = 8;
  localparam int CTL_EN    = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_EVT   = 2;
  localparam int CTL_OTE   = 5;
  localparam int CTL_INV   = 6;
  localparam int INT_TO    = 0;
  localparam int INT_CM    = 1;
  localparam int INT_CE    = 2;
  localparam int MODE_MR   = 0;
  localparam int MODE_CMR  = 2;
  localparam int MODE_AMS  = 3;

  // Values after reset.
  localparam logic [15:0] ILR_RST = 16'hFFFF;
  localparam logic [7:0]  PR_RST  = 8'h00;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } dtm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } dtm_axi_rsp_t;

  typedef struct packed {
    logic [1:0]  mode;
    logic        cmr;
    logic        ams;
    logic        en;
    logic        stall;
    logic [1:0]  evt;
    logic        ote;
    logic        inv;
    logic [15:0] ilr;
    logic [15:0] match;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0]  pr;
    logic [7:0]  pc;
    logic        to;
    logic        cm;
    logic        ce;
    logic        im_to;
    logic        im_cm;
    logic        im_ce;
    logic        trig;
    logic        pwm;
    logic [2:0]  sync;
  } dtm_chan_t;

  typedef struct packed {
    logic [2:0]          cfg;
    dtm_chan_t [NCH-1:0] ch;
    logic                aw_have;
    logic [ADDR_W-1:0]   awaddr_q;
    logic                w_have;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } dtm_state_t;

endpackage : dtm_pkg

// ===== logic/dtm_timer.sv
// Dual 16-bit timer channels with an AXI4-Lite register slave.
//
// Notes on behaviour
// R1: Configuration value 0x4 enables split channel operation.
// R2: Channels A and B share identical logic.
// R3: Sixteen-bit down-counter with optional 8-bit prescaler.
// R4: Mode 0x1 one-shot, 0x2 periodic.
// R5: Enable starts counting from preloaded start value.
// R6: At zero, reload interval and prescale next cycle.
// R7: One-shot stops and clears enable; periodic continues.
// R8: Raw time-out flag sticky; masked flag raises interrupt.
// R9: Trigger enable gives one-cycle pulse at zero.
// R10: Interval load write reloads counter next cycle.
// R11: Stall bit freezes counter until released.
// R12: Prescale p gives p+1 clocks per step.
// R13: Capture bit 0 counts selected input edges.
// R14: Each selected edge decrements until match value.
// R15: Count match sets raw and masked flags.
// R16: After match reload, clear enable, ignore edges.
// R17: Edge time mode ignores the prescaler.
// R18: Edge time counter free-runs from interval load.
// R19: Selected edge captures count and sets event flag.
// R20: Edge time keeps running, reloads at zero.
// R21: Alternate 1, capture 0, mode 0x2 selects PWM.
// R22: PWM reloads at zero, raises no flags.
// R23: PWM high at load, low at match, invertible.
// R24: Capture pin synchronised; each edge acted once.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps

module dtm_timer
  import dtm_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  input  wire dtm_axi_req_t    axi_req_i,
  output dtm_axi_rsp_t         axi_rsp_o,
  input  wire logic [NCH-1:0]  cc_pin_i,
  output logic      [NCH-1:0]  cc_pin_o,
  output logic      [NCH-1:0]  cc_pin_oe_o,
  output logic      [NCH-1:0]  trig_o,
  output logic                 irq_o
);

  dtm_state_t        st_ff;
  dtm_state_t        nxt_st;
  logic [NCH-1:0]    to_ev;
  logic [NCH-1:0]    cm_ev;
  logic [NCH-1:0]    ce_ev;
  logic [NCH-1:0]    ilr_wr;
  logic [NCH-1:0]    pwm_mode;
  logic [NCH-1:0]    edge_sel;
  logic [31:0]       ctl_word;
  logic [31:0]       imr_word;
  logic [31:0]       ris_word;

  // Byte-lane merge of a write into the current register contents.
  function automatic logic [31:0] dtm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : dtm_merge

  // Per-channel pin outputs, trigger pulses and edge selection.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic rise;
    logic fall;
    assign rise = st_ff.ch[g].sync[1] && !st_ff.ch[g].sync[2]; // R24
    assign fall = !st_ff.ch[g].sync[1] && st_ff.ch[g].sync[2]; // R24
    assign edge_sel[g] = (st_ff.ch[g].evt == EVT_RISE) ? rise :
                         (st_ff.ch[g].evt == EVT_FALL) ? fall :
                         (st_ff.ch[g].evt == EVT_BOTH) ? (rise || fall) : 1'b0; // R13
    assign pwm_mode[g] = st_ff.ch[g].ams && !st_ff.ch[g].cmr &&
                         (st_ff.ch[g].mode == MODE_PERIODIC) && (st_ff.cfg == CFG_SPLIT); // R21
    assign cc_pin_o[g]    = pwm_mode[g] && (st_ff.ch[g].pwm ^ st_ff.ch[g].inv); // R23
    assign cc_pin_oe_o[g] = pwm_mode[g];
    assign trig_o[g]   = st_ff.ch[g].trig; // R9
  end

  // Packed views of the shared control and interrupt words.
  always_comb begin
    ctl_word = '0;
    imr_word = '0;
    ris_word = '0;
    for (int i = 0; i < NCH; i++) begin
      ctl_word[CH_STRIDE*i + CTL_EN]        = st_ff.ch[i].en;
      ctl_word[CH_STRIDE*i + CTL_STALL]     = st_ff.ch[i].stall;
      ctl_word[CH_STRIDE*i + CTL_EVT +: 2]  = st_ff.ch[i].evt;
      ctl_word[CH_STRIDE*i + CTL_OTE]       = st_ff.ch[i].ote;
      ctl_word[CH_STRIDE*i + CTL_INV]       = st_ff.ch[i].inv;
      imr_word[CH_STRIDE*i + INT_TO]        = st_ff.ch[i].im_to;
      imr_word[CH_STRIDE*i + INT_CM]        = st_ff.ch[i].im_cm;
      imr_word[CH_STRIDE*i + INT_CE]        = st_ff.ch[i].im_ce;
      ris_word[CH_STRIDE*i + INT_TO]        = st_ff.ch[i].to;
      ris_word[CH_STRIDE*i + INT_CM]        = st_ff.ch[i].cm;
      ris_word[CH_STRIDE*i + INT_CE]        = st_ff.ch[i].ce;
    end
  end

  // Bus handshakes come straight from the state; the interrupt is the masked OR.
  assign axi_rsp_o.awready = !st_ff.aw_have && !st_ff.bvalid;
  assign axi_rsp_o.wready  = !st_ff.w_have && !st_ff.bvalid;
  assign axi_rsp_o.bvalid  = st_ff.bvalid;
  assign axi_rsp_o.bresp   = st_ff.bresp;
  assign axi_rsp_o.arready = !st_ff.rvalid;
  assign axi_rsp_o.rvalid  = st_ff.rvalid;
  assign axi_rsp_o.rdata   = st_ff.rdata;
  assign axi_rsp_o.rresp   = st_ff.rresp;
  assign irq_o             = |(ris_word & imr_word); // R8

  // Next-state logic: bus slave, interrupt clear, channel counters, register writes.
  always_comb begin
    logic              aw_hs;
    logic              w_hs;
    logic              wr_go;
    logic              hit;
    logic [ADDR_W-1:0] wa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic [31:0]       mw;
    logic              run;
    logic              cap_m;
    logic              tim_m;
    dtm_chan_t         c;
    aw_hs  = 1'b0;
    w_hs   = 1'b0;
    wr_go  = 1'b0;
    hit    = 1'b0;
    wa     = '0;
    wd     = '0;
    ws     = '0;
    mw     = '0;
    run    = 1'b0;
    cap_m  = 1'b0;
    tim_m  = 1'b0;
    c      = '0;
    nxt_st = st_ff;
    to_ev  = '0;
    cm_ev  = '0;
    ce_ev  = '0;
    ilr_wr = '0;

    // Write address and data are taken independently and paired here.
    aw_hs = axi_req_i.awvalid && axi_rsp_o.awready;
    w_hs  = axi_req_i.wvalid && axi_rsp_o.wready;
    if (aw_hs) begin
      nxt_st.aw_have  = 1'b1;
      nxt_st.awaddr_q = axi_req_i.awaddr;
    end
    if (w_hs) begin
      nxt_st.w_have  = 1'b1;
      nxt_st.wdata_q = axi_req_i.wdata;
      nxt_st.wstrb_q = axi_req_i.wstrb;
    end
    wa    = st_ff.aw_have ? st_ff.awaddr_q : axi_req_i.awaddr;
    wd    = st_ff.w_have ? st_ff.wdata_q : axi_req_i.wdata;
    ws    = st_ff.w_have ? st_ff.wstrb_q : axi_req_i.wstrb;
    wr_go = (st_ff.aw_have || aw_hs) && (st_ff.w_have || w_hs);
    if (st_ff.bvalid && axi_req_i.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
    end

    // Software clears flags first so that a same-cycle event still sets them.
    if (wr_go && (wa == ADDR_ICR)) begin
      mw = dtm_merge(32'h0000_0000, wd, ws);
      for (int i = 0; i < NCH; i++) begin
        if (mw[CH_STRIDE*i + INT_TO]) nxt_st.ch[i].to = 1'b0; // R8
        if (mw[CH_STRIDE*i + INT_CM]) nxt_st.ch[i].cm = 1'b0;
        if (mw[CH_STRIDE*i + INT_CE]) nxt_st.ch[i].ce = 1'b0;
      end
    end

    // Channel counters; both channels run the same logic.
    for (int i = 0; i < NCH; i++) begin // R2
      c = st_ff.ch[i];
      nxt_st.ch[i].sync = {c.sync[1:0], cc_pin_i[i]}; // R24
      nxt_st.ch[i].trig = 1'b0; // R9
      run   = (st_ff.cfg == CFG_SPLIT) && c.en && !c.stall; // R1 R11
      cap_m = !c.ams && (c.mode == MODE_CAPTURE);
      tim_m = !c.ams && ((c.mode == MODE_ONESHOT) || (c.mode == MODE_PERIODIC)); // R4
      if (run && cap_m && !c.cmr) begin
        // Edge count: step once per selected edge, stop at the match value.
        if (edge_sel[i]) begin
          if (16'(c.cnt - 16'h0001) == c.match) begin // R14
            cm_ev[i]            = 1'b1; // R15
            nxt_st.ch[i].cnt    = c.ilr; // R16
            nxt_st.ch[i].en     = 1'b0; // R16
          end else begin
            nxt_st.ch[i].cnt = 16'(c.cnt - 16'h0001); // R14
          end
        end
      end else if (run && cap_m && c.cmr) begin
        // Edge time: free-run every clock, no prescaler, capture on edges.
        nxt_st.ch[i].cnt = (c.cnt == 16'h0000) ? c.ilr : 16'(c.cnt - 16'h0001); // R17 R18 R20
        if (edge_sel[i]) begin
          ce_ev[i]         = 1'b1; // R19
          nxt_st.ch[i].cap = c.cnt; // R19
        end
      end else if (run && (tim_m || pwm_mode[i])) begin
        // Timer and PWM: prescaler gates each counter step.
        if (c.pc != 8'h00) begin
          nxt_st.ch[i].pc = 8'(c.pc - 8'h01); // R12
        end else begin
          nxt_st.ch[i].pc = c.pr; // R12
          if (c.cnt == 16'h0000) begin
            nxt_st.ch[i].cnt = c.ilr; // R6 R22
            if (tim_m) begin
              to_ev[i]          = 1'b1;
              nxt_st.ch[i].trig = c.ote; // R9
              if (c.mode == MODE_ONESHOT) begin
                nxt_st.ch[i].en = 1'b0; // R7
              end
            end
          end else begin
            nxt_st.ch[i].cnt = 16'(c.cnt - 16'h0001); // R3 R5
          end
        end
      end
      // PWM level: set at the start value, cleared at the match value.
      if (!pwm_mode[i]) begin
        nxt_st.ch[i].pwm = 1'b0;
      end else if (c.en && (c.cnt == c.ilr)) begin
        nxt_st.ch[i].pwm = 1'b1; // R23
      end else if (c.en && (c.cnt == c.match)) begin
        nxt_st.ch[i].pwm = 1'b0; // R23
      end
      if (to_ev[i]) nxt_st.ch[i].to = 1'b1; // R8
      if (cm_ev[i]) nxt_st.ch[i].cm = 1'b1; // R15
      if (ce_ev[i]) nxt_st.ch[i].ce = 1'b1; // R19
    end

    // Register writes; a software enable write wins over a hardware stop.
    if (wr_go) begin
      hit = (wa == ADDR_ICR);
      if (wa == ADDR_CFG) begin
        hit = 1'b1;
        mw  = dtm_merge({29'h0, st_ff.cfg}, wd, ws);
        nxt_st.cfg = mw[2:0]; // R1
      end else if (wa == ADDR_CTL) begin
        hit = 1'b1;
        mw  = dtm_merge(ctl_word, wd, ws);
        for (int i = 0; i < NCH; i++) begin
          nxt_st.ch[i].en    = mw[CH_STRIDE*i + CTL_EN]; // R5
          nxt_st.ch[i].stall = mw[CH_STRIDE*i + CTL_STALL]; // R11
          nxt_st.ch[i].evt   = mw[CH_STRIDE*i + CTL_EVT +: 2];
          nxt_st.ch[i].ote   = mw[CH_STRIDE*i + CTL_OTE];
          nxt_st.ch[i].inv   = mw[CH_STRIDE*i + CTL_INV];
        end
      end else if (wa == ADDR_IMR) begin
        hit = 1'b1;
        mw  = dtm_merge(imr_word, wd, ws);
        for (int i = 0; i < NCH; i++) begin
          nxt_st.ch[i].im_to = mw[CH_STRIDE*i + INT_TO];
          nxt_st.ch[i].im_cm = mw[CH_STRIDE*i + INT_CM];
          nxt_st.ch[i].im_ce = mw[CH_STRIDE*i + INT_CE];
        end
      end
      for (int i = 0; i < NCH; i++) begin
        if (wa == 8'(ADDR_MODE0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          mw  = dtm_merge({28'h0, st_ff.ch[i].ams, st_ff.ch[i].cmr, st_ff.ch[i].mode}, wd, ws);
          nxt_st.ch[i].mode = mw[MODE_MR +: 2]; // R4
          nxt_st.ch[i].cmr  = mw[MODE_CMR]; // R13
          nxt_st.ch[i].ams  = mw[MODE_AMS]; // R21
        end else if (wa == 8'(ADDR_ILR0 + ADDR_STEP * i)) begin
          hit       = 1'b1;
          ilr_wr[i] = 1'b1;
          mw  = dtm_merge({16'h0, st_ff.ch[i].ilr}, wd, ws);
          nxt_st.ch[i].ilr = mw[15:0];
          nxt_st.ch[i].cnt = mw[15:0]; // R10
          nxt_st.ch[i].pc  = st_ff.ch[i].pr; // R10
        end else if (wa == 8'(ADDR_MAT0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          mw  = dtm_merge({16'h0, st_ff.ch[i].match}, wd, ws);
          nxt_st.ch[i].match = mw[15:0];
        end else if (wa == 8'(ADDR_PR0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          mw  = dtm_merge({24'h0, st_ff.ch[i].pr}, wd, ws);
          nxt_st.ch[i].pr = mw[7:0]; // R3
        end
      end
      nxt_st.bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Read port: one read in flight, data registered on acceptance.
    if (st_ff.rvalid && axi_req_i.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && axi_rsp_o.arready) begin
      hit          = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      nxt_st.rvalid = 1'b1;
      if (axi_req_i.araddr == ADDR_CFG) begin
        nxt_st.rdata = {29'h0, st_ff.cfg};
      end else if (axi_req_i.araddr == ADDR_CTL) begin
        nxt_st.rdata = ctl_word;
      end else if (axi_req_i.araddr == ADDR_IMR) begin
        nxt_st.rdata = imr_word;
      end else if (axi_req_i.araddr == ADDR_RIS) begin
        nxt_st.rdata = ris_word; // R8
      end else if (axi_req_i.araddr == ADDR_MIS) begin
        nxt_st.rdata = ris_word & imr_word; // R8 R15
      end else if (axi_req_i.araddr == ADDR_ICR) begin
        nxt_st.rdata = 32'h0000_0000;
      end else begin
        hit = 1'b0;
      end
      for (int i = 0; i < NCH; i++) begin
        c = st_ff.ch[i];
        if (axi_req_i.araddr == 8'(ADDR_MODE0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          nxt_st.rdata = {28'h0, c.ams, c.cmr, c.mode};
        end else if (axi_req_i.araddr == 8'(ADDR_ILR0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          nxt_st.rdata = {16'h0, c.ilr};
        end else if (axi_req_i.araddr == 8'(ADDR_MAT0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          nxt_st.rdata = {16'h0, c.match};
        end else if (axi_req_i.araddr == 8'(ADDR_PR0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          nxt_st.rdata = {24'h0, c.pr};
        end else if (axi_req_i.araddr == 8'(ADDR_VAL0 + ADDR_STEP * i)) begin
          hit = 1'b1;
          nxt_st.rdata = {16'h0, (!c.ams && c.cmr) ? c.cap : c.cnt}; // R19
        end
      end
      nxt_st.rresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // State register; counter and interval load come up at all ones, prescaler and match at zero.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        st_ff.ch[i].ilr <= ILR_RST; // R18
        st_ff.ch[i].cnt <= ILR_RST;
        st_ff.ch[i].pr  <= PR_RST;
        st_ff.ch[i].pc  <= PR_RST;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // Checks on each channel's counter behaviour.
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    sequence s_timeout;
      to_ev[g] && !ilr_wr[g];
    endsequence
    sequence s_reload;
      st_ff.ch[g].cnt == $past(st_ff.ch[g].ilr);
    endsequence

    a_trig_single_pulse: assert property (trig_o[g] // R9
      |-> $past(to_ev[g]) && $past(st_ff.ch[g].ote) ##1 !trig_o[g])
      else $error("Trigger pulse not single cycle.");
    a_oneshot_clears_en: assert property (to_ev[g] // R7
      && st_ff.ch[g].mode == MODE_ONESHOT && !nxt_st.ch[g].en
      |=> !st_ff.ch[g].en ##1 ($stable(st_ff.ch[g].cnt) || $past(ilr_wr[g])))
      else $error("One-shot did not stop.");
    a_zero_reload: assert property (s_timeout |=> s_reload) // R6
      else $error("Counter did not reload at zero.");
    a_flag_sticky: assert property (st_ff.ch[g].to && !nxt_st.bvalid // R8
      |=> st_ff.ch[g].to) else $error("Time-out flag dropped.");
    a_stall_freeze: assert property (st_ff.ch[g].stall && !ilr_wr[g] // R11
      |=> $stable(st_ff.ch[g].cnt)) else $error("Counter moved while stalled.");
    a_pwm_no_flags: assert property (pwm_mode[g] // R22
      |-> !to_ev[g] && !cm_ev[g] && !ce_ev[g]) else $error("Flag raised in PWM mode.");
    a_edge_capture: assert property (ce_ev[g] // R19
      |=> st_ff.ch[g].cap == $past(st_ff.ch[g].cnt) && st_ff.ch[g].ce)
      else $error("Edge time capture wrong.");
    a_match_stop: assert property (cm_ev[g] && !ilr_wr[g] && !nxt_st.ch[g].en // R16
      |=> !st_ff.ch[g].en && st_ff.ch[g].cnt == $past(st_ff.ch[g].ilr))
      else $error("Edge count did not stop.");
    a_edge_time_step: assert property (st_ff.cfg == CFG_SPLIT && st_ff.ch[g].en // R17
      && !st_ff.ch[g].stall && !st_ff.ch[g].ams && st_ff.ch[g].mode == MODE_CAPTURE
      && st_ff.ch[g].cmr && st_ff.ch[g].cnt != 16'h0000 && !ilr_wr[g]
      |=> st_ff.ch[g].cnt == 16'($past(st_ff.ch[g].cnt) - 16'h0001))
      else $error("Edge time counter skipped.");
  end

endmodule : dtm_timer

// ===== tb/dtm_pin_model.sv
// Model of the external signal source on the capture pin.
`timescale 1ns/10ps

module dtm_pin_model (
  input  wire logic       ref_clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] n_i,
  output logic            pin_o
);
  logic [3:0] left_ff;
  logic [1:0] gap_ff;

  // Toggles the pin n times, holding each level four clocks so every edge is seen once.
  initial begin
    pin_o = 1'h0;
    left_ff = 4'h0;
    gap_ff = 2'h0;
  end
  always @(posedge ref_clk_i) begin
    if (go_i) begin
      left_ff <= n_i;
      gap_ff <= 2'h0;
    end else if (left_ff != 4'h0) begin
      gap_ff <= gap_ff + 2'h1;
      if (gap_ff == 2'h3) begin
        pin_o <= ~pin_o;
        left_ff <= left_ff - 4'h1;
      end
    end
  end
endmodule : dtm_pin_model

// ===== tb/tb.sv
// Self-checking testbench of the dual 16-bit timer block.
`timescale 1ns/10ps

module tb;
  import dtm_pkg::*;
  logic ref_clk_i, rst_i, go, pin;
  logic [3:0] n;
  dtm_axi_req_t req;
  dtm_axi_rsp_t rsp;
  logic [1:0] cc_pin_o, cc_pin_oe_o, trig_o;
  logic irq_o;
  int error_cnt, total_checks, cyc;
  logic [31:0] rd;
  logic [1:0] rr;

  dtm_timer dtm_timer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .axi_req_i(req),
    .axi_rsp_o(rsp), .cc_pin_i({pin, pin}), .cc_pin_o(cc_pin_o), .cc_pin_oe_o(cc_pin_oe_o),
    .trig_o(trig_o), .irq_o(irq_o));
  dtm_pin_model dtm_pin_model_i (.ref_clk_i(ref_clk_i), .go_i(go), .n_i(n), .pin_o(pin));

  // Clock generation and the hang limit.
  initial begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    req.bready <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (rsp.bvalid !== 1'h1);
    rr = rsp.bresp;
    req.bready <= 1'h0;
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    @(posedge ref_clk_i);
    req.araddr <= a;
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (rsp.rvalid !== 1'h1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'h0;
  endtask : rdw

  task automatic wait_trig(input int ch);
    int k;
    for (k = 0; k < 2000 && trig_o[ch] !== 1'h1; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask : wait_trig

  // Reset values and an unmapped address.
  task automatic t_reset();
    rdw(ADDR_ILR0);
    chk("ilr", rd, 32'h0000FFFF);
    rdw(ADDR_PR0);
    chk("pr", rd, 32'h00000000);
    rdw(8'hFC);
    chk("resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
  endtask : t_reset

  // One-shot time-out: trigger pulse, sticky flag, interrupt, enable cleared.
  task automatic t_oneshot();
    wr(ADDR_CFG, 32'h4);
    wr(ADDR_MODE0, 32'h1);
    wr(ADDR_ILR0, 32'h5);
    wr(ADDR_IMR, 32'h1);
    wr(ADDR_CTL, 32'h21);
    wait_trig(0);
    chk("trig", {31'h0, trig_o[0]}, 32'h1);
    @(posedge ref_clk_i);
    #1 chk("trig_end", {31'h0, trig_o[0]}, 32'h0);
    chk("irq", {31'h0, irq_o}, 32'h1);
    rdw(ADDR_RIS);
    chk("ris", rd, 32'h1);
    rdw(ADDR_CTL);
    chk("en", {31'h0, rd[0]}, 32'h0);
    wr(ADDR_ICR, 32'h1);
    rdw(ADDR_RIS);
    chk("ris_clr", rd, 32'h0);
  endtask : t_oneshot

  // Periodic with prescale 1 and load 3: eight clocks between pulses, then stall.
  task automatic t_periodic();
    int k;
    logic [31:0] v;
    wr(ADDR_MODE0, 32'h2);
    wr(ADDR_PR0, 32'h1);
    wr(ADDR_ILR0, 32'h3);
    wr(ADDR_CTL, 32'h21);
    wait_trig(0);
    @(posedge ref_clk_i);
    #1;
    for (k = 1; k < 50 && trig_o[0] !== 1'h1; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk("period", k, 8);
    wr(ADDR_CTL, 32'h23);
    rdw(ADDR_VAL0);
    v = rd;
    repeat (6) @(posedge ref_clk_i);
    rdw(ADDR_VAL0);
    chk("stall", rd, v);
    wr(ADDR_CTL, 32'h0);
  endtask : t_periodic

  // Edge count: six edges offered, four counted, then stop and reload.
  task automatic t_edgecount();
    wr(ADDR_ICR, 32'hFFFFFFFF);
    wr(ADDR_PR0, 32'h0);
    wr(ADDR_MODE0, 32'h3);
    wr(ADDR_ILR0, 32'hA);
    wr(ADDR_MAT0, 32'h6);
    wr(ADDR_CTL, 32'hD);
    @(posedge ref_clk_i);
    go <= 1'h1;
    n <= 4'h6;
    @(posedge ref_clk_i);
    go <= 1'h0;
    repeat (40) @(posedge ref_clk_i);
    rdw(ADDR_RIS);
    chk("cm", {31'h0, rd[1]}, 32'h1);
    rdw(ADDR_CTL);
    chk("en", {31'h0, rd[0]}, 32'h0);
    rdw(ADDR_VAL0);
    chk("reload", {16'h0, rd[15:0]}, 32'hA);
  endtask : t_edgecount

  // Edge time on channel A: prescale ignored, one rising edge captured and held.
  task automatic t_edgetime();
    logic [31:0] v;
    wr(ADDR_ICR, 32'hFFFFFFFF);
    wr(ADDR_PR0, 32'hFF);
    wr(ADDR_MODE0, 32'h7);
    wr(ADDR_ILR0, 32'h1000);
    wr(ADDR_CTL, 32'h1);
    @(posedge ref_clk_i);
    go <= 1'h1;
    n <= 4'h2;
    @(posedge ref_clk_i);
    go <= 1'h0;
    repeat (30) @(posedge ref_clk_i);
    rdw(ADDR_VAL0);
    v = rd;
    chk("cap_range", {31'h0, v >= 32'h0FF0 && v < 32'h1000}, 32'h1);
    rdw(ADDR_RIS);
    chk("ce", {31'h0, rd[2]}, 32'h1);
    rdw(ADDR_VAL0);
    chk("cap_hold", rd, v);
    rdw(ADDR_CTL);
    chk("run", {31'h0, rd[0]}, 32'h1);
    wr(ADDR_CTL, 32'h0);
    wr(ADDR_PR0, 32'h0);
  endtask : t_edgetime

  // PWM on channel B: load 9, match 3, six high clocks in ten, no flags.
  task automatic t_pwm();
    int k, hi;
    wr(ADDR_ICR, 32'hFFFFFFFF);
    wr(ADDR_MODE0 + ADDR_STEP, 32'hA);
    wr(ADDR_ILR0 + ADDR_STEP, 32'h9);
    wr(ADDR_MAT0 + ADDR_STEP, 32'h3);
    wr(ADDR_CTL, 32'h100);
    repeat (20) @(posedge ref_clk_i);
    hi = 0;
    for (k = 0; k < 10; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (cc_pin_o[1] === 1'h1) hi++;
    end
    chk("oe", {31'h0, cc_pin_oe_o[1]}, 32'h1);
    chk("oe_a", {31'h0, cc_pin_oe_o[0]}, 32'h0);
    chk("duty", hi, 6);
    rdw(ADDR_RIS);
    chk("flags", {24'h0, rd[15:8]}, 32'h0);
  endtask : t_pwm

  // Main sequence.
  initial begin
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    req = '0;
    go = 1'h0;
    n = 4'h0;
    rst_i = 1'h1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_oneshot();
    t_periodic();
    t_edgecount();
    t_edgetime();
    t_pwm();
    summarize();
  end
endmodule : tb
